// ---- design/cta_counter_array.v ----
// Shared counter of the counter array with snapshot reads and interrupt tree
`timescale 1ns/100ps
`include "cta_defines.vh"
// Notes on behaviour
// - Sixteen-bit up-counter from two bytes
// - Low read snapshots high byte for later
// - Reads never disturb counting
// - Three-bit field picks counting source
// - External input counts falling edges, limited rate
// - Oscillator-over-eight ticks synchronised to clock
// - Rollover from all ones sets overflow
// - Overflow requests interrupt only when enabled
// - Overflow flag cleared only by software
// - Idle-stop clear: counts during idle
// - Intermediate flag on selected bit overflow
// - Cycle length picks bits seven to fourteen
// - One event flag per channel
// - Flags set regardless of enables
// - Each flag gated by own enable
// - Request needs global and array enables
// - Three channels, each with routed line
// - Reset enters watchdog mode, restricting access
module cta_counter_array (
  input wire clk,
  input wire reset,
  input wire counter_run,
  input wire [2:0] timebase_select,
  input wire timer0_overflow,
  input wire external_count_input,
  input wire ext_osc_div8,
  input wire cpu_idle,
  input wire idle_stop_control,
  input wire read_low_strobe,
  input wire read_high_strobe,
  input wire write_low_strobe,
  input wire write_high_strobe,
  input wire [7:0] write_data,
  input wire [2:0] cycle_length_field,
  input wire overflow_irq_enable,
  input wire intermediate_irq_enable,
  input wire [2:0] channel_irq_enable,
  input wire global_irq_enable,
  input wire array_irq_enable,
  input wire clear_overflow_flag,
  input wire clear_intermediate_flag,
  input wire [2:0] clear_channel_flag,
  input wire [2:0] channel_event,
  input wire watchdog_disable,
  input wire [2:0] channel_io_enable,
  input wire [2:0] channel_drive,
  input wire [2:0] channel_io_line_in,
  output reg [7:0] read_data,
  output reg [15:0] counter_value,
  output reg counter_overflow_flag,
  output reg intermediate_overflow_flag,
  output reg [2:0] channel_event_flag,
  output reg irq_request,
  output reg watchdog_mode,
  output reg [2:0] channel_io_line_out,
  output reg [2:0] channel_io_line_oe_n,
  output reg [2:0] channel_input
);
  wire tick;
  wire advance;
  wire count_write;
  wire rollover;
  wire inter_overflow;
  wire [4:0] flag_set;
  wire [4:0] flag_clear;
  wire [4:0] flag_q;
  wire [4:0] flag_enable;
  reg [7:0] snapshot;
  reg [15:0] low_mask;
  reg [15:0] next_count;

  // ==========================================================
  // Timebase
  cta_tick_gen u_tick (
    .clk(clk),
    .reset(reset),
    .timebase_select(timebase_select),
    .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input),
    .ext_osc_div8(ext_osc_div8),
    .tick(tick)
  );

  // Idle freeze only when asked; otherwise idle has no effect
  assign advance = tick & counter_run & ~(idle_stop_control & cpu_idle);

  // ==========================================================
  // Counter
  // A write overrides the tick, so no overflow can be flagged in that cycle
  assign count_write = (write_low_strobe | write_high_strobe) & ~watchdog_mode;
  assign rollover = advance & ~count_write & (counter_value == `CTA_COUNT_MAX);

  // Mask of bits below and including the selected carry-out position
  always @* begin
    low_mask = 16'h00ff;
    case (cycle_length_field)
      3'h0: low_mask = 16'h00ff;
      3'h1: low_mask = 16'h01ff;
      3'h2: low_mask = 16'h03ff;
      3'h3: low_mask = 16'h07ff;
      3'h4: low_mask = 16'h0fff;
      3'h5: low_mask = 16'h1fff;
      3'h6: low_mask = 16'h3fff;
      3'h7: low_mask = 16'h7fff;
      default: low_mask = 16'h00ff;
    endcase
  end

  assign inter_overflow = advance & ~count_write & ((counter_value & low_mask) == low_mask);

  // A low write beats a high write; only watchdog lockout blocks writes; a write beats a tick
  always @* begin
    next_count = counter_value;
    if (write_low_strobe & ~watchdog_mode) begin
      next_count = {counter_value[15:8], write_data};
    end else if (write_high_strobe & ~watchdog_mode) begin
      next_count = {write_data, counter_value[7:0]};
    end else if (advance) begin
      next_count = counter_value + 16'h0001;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      counter_value <= `CTA_COUNT_RESET;
    end else begin
      counter_value <= next_count;
    end
  end

  // ==========================================================
  // Byte reads
  always @(posedge clk) begin
    if (reset) begin
      snapshot <= `CTA_BYTE_RESET;
      read_data <= `CTA_BYTE_RESET;
    end else if (read_low_strobe) begin
      snapshot <= counter_value[15:8];
      read_data <= counter_value[7:0];
    end else if (read_high_strobe) begin
      read_data <= snapshot;
    end
  end

  // ==========================================================
  // Event flags
  assign flag_set = {channel_event, inter_overflow, rollover};
  assign flag_clear = {clear_channel_flag, clear_intermediate_flag, clear_overflow_flag};
  assign flag_enable = {channel_irq_enable, intermediate_irq_enable, overflow_irq_enable};

  genvar i;
  generate
    for (i = 0; i < `CTA_FLAG_COUNT; i = i + 1) begin : g_flag
      cta_event_flag u_flag (
        .clk(clk),
        .reset(reset),
        .set(flag_set[i]),
        .clear(flag_clear[i]),
        .flag(flag_q[i])
      );
    end
  endgenerate

  // Flags mirrored to flops so the outputs stay registered
  always @(posedge clk) begin
    if (reset) begin
      counter_overflow_flag <= 1'b0;
      intermediate_overflow_flag <= 1'b0;
      channel_event_flag <= 3'h0;
      irq_request <= 1'b0;
    end else begin
      counter_overflow_flag <= flag_q[`CTA_FLAG_OVF];
      intermediate_overflow_flag <= flag_q[`CTA_FLAG_INTER];
      channel_event_flag <= flag_q[4:2];
      irq_request <= global_irq_enable & array_irq_enable & (|(flag_q & flag_enable));
    end
  end

  // ==========================================================
  // Watchdog mode and channel lines
  always @(posedge clk) begin
    if (reset) begin
      watchdog_mode <= 1'b1;
    end else if (watchdog_disable) begin
      watchdog_mode <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      channel_io_line_out <= 3'h0;
      channel_io_line_oe_n <= 3'h7;
      channel_input <= 3'h0;
    end else begin
      channel_io_line_out <= channel_drive;
      channel_io_line_oe_n <= ~channel_io_enable;
      channel_input <= channel_io_line_in;
    end
  end
endmodule // cta_counter_array

// ---- design/cta_defines.vh ----
// Constants for the counter array timebase and interrupt block
`ifndef CTA_DEFINES_VH
`define CTA_DEFINES_VH

// Timebase select encodings
`define CTA_TB_DIV12 3'h0
`define CTA_TB_DIV4 3'h1
`define CTA_TB_TIMER0 3'h2
`define CTA_TB_EXT_INPUT 3'h3
`define CTA_TB_SYSCLK 3'h4
`define CTA_TB_EXT_OSC8 3'h5

// Prescaler terminal counts
`define CTA_DIV12_LAST 4'hb
`define CTA_DIV4_LAST 2'h3

// Counter layout and reset values
`define CTA_COUNT_WIDTH 16
`define CTA_COUNT_RESET 16'h0000
`define CTA_COUNT_MAX 16'hffff
`define CTA_BYTE_RESET 8'h00
`define CTA_INTER_BASE_BIT 7

// Event flag positions in the flag vector
`define CTA_FLAG_COUNT 5
`define CTA_FLAG_OVF 0
`define CTA_FLAG_INTER 1
`define CTA_FLAG_CH0 2

`endif

// ---- design/cta_event_flag.v ----
// Sticky event flag where a hardware set beats a software clear
`timescale 1ns/100ps
module cta_event_flag (
  input wire clk,
  input wire reset,
  input wire set,
  input wire clear,
  output reg flag
);
  always @(posedge clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule // cta_event_flag

// ---- design/cta_tick_gen.v ----
// Timebase tick generator for the shared counter
`timescale 1ns/100ps
`include "cta_defines.vh"
module cta_tick_gen (
  input wire clk,
  input wire reset,
  input wire [2:0] timebase_select,
  input wire timer0_overflow,
  input wire external_count_input,
  input wire ext_osc_div8,
  output reg tick
);
  reg [3:0] div12;
  reg [1:0] div4;
  reg ext_input_prev;
  reg osc_sync1;
  reg osc_sync2;
  reg osc_prev;
  reg next_tick;

  // ==========================================================
  // Prescalers and edge detectors
  always @(posedge clk) begin
    if (reset) begin
      div12 <= 4'h0;
      div4 <= 2'h0;
      ext_input_prev <= 1'b1;
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      div12 <= (div12 == `CTA_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      div4 <= div4 + 2'h1;
      ext_input_prev <= external_count_input;
      // Oscillator divider runs in its own time; two flops before use
      osc_sync1 <= ext_osc_div8;
      osc_sync2 <= osc_sync1;
      osc_prev <= osc_sync2;
    end
  end

  // ==========================================================
  // Source selection
  always @* begin
    case (timebase_select)
      `CTA_TB_DIV12: next_tick = (div12 == `CTA_DIV12_LAST);
      `CTA_TB_DIV4: next_tick = (div4 == `CTA_DIV4_LAST);
      `CTA_TB_TIMER0: next_tick = timer0_overflow;
      `CTA_TB_EXT_INPUT: next_tick = ext_input_prev & ~external_count_input;
      `CTA_TB_SYSCLK: next_tick = 1'b1;
      `CTA_TB_EXT_OSC8: next_tick = osc_sync2 & ~osc_prev;
      default: next_tick = 1'b0; // Reserved codes never count
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end
endmodule // cta_tick_gen

// ---- sim/cta_assertions.sv ----
// Port checker for the counter array block
`timescale 1ns/100ps
module cta_assertions (
  input wire clk,
  input wire reset,
  input wire [15:0] counter_value,
  input wire [7:0] read_data,
  input wire read_low_strobe,
  input wire read_high_strobe,
  input wire counter_overflow_flag,
  input wire clear_overflow_flag,
  input wire [2:0] channel_event,
  input wire [2:0] channel_event_flag,
  input wire [2:0] clear_channel_flag,
  input wire irq_request,
  input wire global_irq_enable,
  input wire array_irq_enable,
  input wire cpu_idle,
  input wire idle_stop_control
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========
  // Properties
  sequence low_then_high;
    read_low_strobe ##1 read_high_strobe;
  endsequence
  low_read_a: assert property (read_low_strobe |=> read_data == $past(counter_value[7:0]))
    else $error("low byte read wrong");
  snap_read_a: assert property (low_then_high |=> read_data == $past(counter_value[15:8], 2))
    else $error("high byte not from snapshot");
  ovf_set_a: assert property (counter_value == 16'h0000 && $past(counter_value) == 16'hffff |=> counter_overflow_flag)
    else $error("rollover left flag low");
  ovf_hold_a: assert property ($fell(counter_overflow_flag) |-> $past(clear_overflow_flag, 2))
    else $error("overflow flag fell unasked");
  chan_set_a: assert property (channel_event[1] |-> ##2 channel_event_flag[1])
    else $error("channel flag not set");
  chan_hold_a: assert property ($fell(channel_event_flag[0]) |-> $past(clear_channel_flag[0], 2))
    else $error("channel flag fell unasked");
  irq_gate_a: assert property ((!global_irq_enable || !array_irq_enable) [*3] |-> !irq_request)
    else $error("request while disabled");
  idle_freeze_a: assert property ((cpu_idle && idle_stop_control) [*2] |-> $stable(counter_value))
    else $error("counted while frozen");
endmodule // cta_assertions

// ---- sim/cta_core_model.sv ----
// Outside sources: timer 0 overflow, count pin and slow oscillator
`timescale 1ns/100ps
module cta_core_model (
  input wire clk,
  output logic timer0_overflow = 1'h0,
  output logic external_count_input = 1'h1,
  output logic ext_osc_div8 = 1'h0
);
  logic [2:0] phase = 3'h0;
  // Own delay, but every edge lands on a clk falling edge, half a cycle from sampling
  always #100 ext_osc_div8 = ~ext_osc_div8;
  always @(posedge clk) begin
    phase <= phase + 3'h1;
    timer0_overflow <= phase == 3'h7;
    // Eight-clock period stays under the clk/4 limit
    external_count_input <= phase < 3'h4;
  end
endmodule // cta_core_model

// ---- sim/testbench.sv ----
// Self-checking bench for the counter array block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0, reset = 1'h1, counter_run = 1'h0, cpu_idle = 1'h0, idle_stop_control = 1'h0;
  logic read_low_strobe = 1'h0, read_high_strobe = 1'h0, write_low_strobe = 1'h0, write_high_strobe = 1'h0;
  logic watchdog_disable = 1'h0, overflow_irq_enable = 1'h0, global_irq_enable = 1'h0, array_irq_enable = 1'h0;
  logic clear_overflow_flag = 1'h0, clear_intermediate_flag = 1'h0, intermediate_irq_enable = 1'h0;
  logic [2:0] channel_io_enable = 3'h0, channel_drive = 3'h0, channel_io_line_in = 3'h5;
  wire watchdog_mode;
  wire [2:0] channel_io_line_out, channel_io_line_oe_n, channel_input;
  logic [2:0] timebase_select = 3'h4, cycle_length_field = 3'h3, clear_channel_flag = 3'h0, channel_event = 3'h0;
  logic [7:0] write_data = 8'h00;
  wire timer0_overflow, external_count_input, ext_osc_div8, irq_request, counter_overflow_flag;
  wire intermediate_overflow_flag;
  wire [2:0] channel_event_flag;
  wire [7:0] read_data;
  wire [15:0] counter_value;
  int n_errors = 0;
  int checked = 0;
  always #25 clk = ~clk;
  cta_core_model cta_core_model_i (.clk, .timer0_overflow, .external_count_input, .ext_osc_div8);
  cta_counter_array cta_counter_array_i (.clk, .reset, .counter_run, .timebase_select, .timer0_overflow,
    .external_count_input, .ext_osc_div8, .cpu_idle, .idle_stop_control, .read_low_strobe, .read_high_strobe,
    .write_low_strobe, .write_high_strobe, .write_data, .cycle_length_field, .overflow_irq_enable,
    .intermediate_irq_enable, .channel_irq_enable(3'h4), .global_irq_enable, .array_irq_enable,
    .clear_overflow_flag, .clear_intermediate_flag, .clear_channel_flag, .channel_event, .watchdog_disable,
    .channel_io_enable, .channel_drive, .channel_io_line_in, .read_data, .counter_value,
    .counter_overflow_flag, .intermediate_overflow_flag, .channel_event_flag, .irq_request, .watchdog_mode,
    .channel_io_line_out, .channel_io_line_oe_n, .channel_input);
  task cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [15:0] v);
    counter_run = 1'h0;
    write_data = v[7:0];
    write_low_strobe = 1'h1;
    cy(1);
    write_low_strobe = 1'h0;
    write_high_strobe = 1'h1;
    write_data = v[15:8];
    cy(1);
    write_high_strobe = 1'h0;
    cy(1);
  endtask
  task t_rd;
    logic [15:0] v;
    wr(16'h5555);
    check("wdog", counter_value, 16'h0000);
    check("wdmode", {15'h0000, watchdog_mode}, 16'h0001);
    watchdog_disable = 1'h1;
    cy(1);
    watchdog_disable = 1'h0;
    cy(1);
    check("wdmode", {15'h0000, watchdog_mode}, 16'h0000);
    // Low read at 12ff: the live high byte has moved on by the high read
    wr(16'h12fc);
    counter_run = 1'h1;
    cy(3);
    v = counter_value;
    read_low_strobe = 1'h1;
    cy(1);
    read_low_strobe = 1'h0;
    read_high_strobe = 1'h1;
    check("low", {8'h00, read_data}, {8'h00, v[7:0]});
    cy(1);
    read_high_strobe = 1'h0;
    check("high", {8'h00, read_data}, {8'h00, v[15:8]});
    check("run", counter_value, v + 16'h0002);
  endtask
  task t_src;
    int e[8] = '{4, 12, 6, 6, 48, 12, 0, 0};
    logic [15:0] v;
    cpu_idle = 1'h1;
    for (int i = 0; i < 8; i++) begin
      timebase_select = i[2:0];
      cy(4);
      v = counter_value;
      cy(48);
      check("rate", {15'h0000, counter_value - v - e[i] + 1 <= (i > 5 ? 1 : 2)}, 16'h0001);
    end
    timebase_select = 3'h4;
  endtask
  task t_ovf;
    clear_intermediate_flag = 1'h1;
    wr(16'h07fd);
    clear_intermediate_flag = 1'h0;
    check("mid0", {15'h0000, intermediate_overflow_flag}, 16'h0000);
    counter_run = 1'h1;
    cy(6);
    check("mid1", {15'h0000, intermediate_overflow_flag}, 16'h0001);
    wr(16'hfffd);
    counter_run = 1'h1;
    cy(6);
    check("ovf", {15'h0000, counter_overflow_flag}, 16'h0001);
    global_irq_enable = 1'h1;
    array_irq_enable = 1'h1;
    cy(4);
    check("irq", {15'h0000, irq_request}, 16'h0000);
    overflow_irq_enable = 1'h1;
    cy(4);
    check("irq", {15'h0000, irq_request}, 16'h0001);
    array_irq_enable = 1'h0;
    cy(4);
    check("irq", {15'h0000, irq_request}, 16'h0000);
    check("ovf", {15'h0000, counter_overflow_flag}, 16'h0001);
    clear_overflow_flag = 1'h1;
    cy(1);
    clear_overflow_flag = 1'h0;
    array_irq_enable = 1'h1;
    cy(4);
    check("ovf", {15'h0000, counter_overflow_flag}, 16'h0000);
    check("irq", {15'h0000, irq_request}, 16'h0000);
    intermediate_irq_enable = 1'h1;
    cy(4);
    check("irq", {15'h0000, irq_request}, 16'h0001);
    intermediate_irq_enable = 1'h0;
    cy(4);
    check("irq", {15'h0000, irq_request}, 16'h0000);
  endtask
  task t_chan;
    logic [15:0] v;
    idle_stop_control = 1'h1;
    cy(2);
    v = counter_value;
    for (int i = 0; i < 3; i++) begin
      channel_event = 3'h1 << i;
      cy(1);
      channel_event = 3'h0;
      cy(3);
      check("chan", {13'h0000, channel_event_flag}, 16'h0001 << i);
      check("irq", {15'h0000, irq_request}, {15'h0000, i == 2});
      clear_channel_flag = 3'h1 << i;
      cy(1);
      clear_channel_flag = 3'h0;
      cy(3);
    end
    check("idle", counter_value, v);
    channel_io_enable = 3'h5;
    channel_drive = 3'h6;
    channel_io_line_in = 3'h3;
    cy(2);
    check("io_out", {13'h0000, channel_io_line_out}, 16'h0006);
    check("io_oe_n", {13'h0000, channel_io_line_oe_n}, 16'h0002);
    check("io_in", {13'h0000, channel_input}, 16'h0003);
  endtask
  task test_done;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cy(20);
    reset = 1'h0;
    t_rd;
    t_src;
    t_ovf;
    t_chan;
    test_done;
  end
  // Tests take about 520 cycles; this allows some 4000
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
endmodule // testbench
bind cta_counter_array cta_assertions cta_assertions_i (.clk, .reset, .counter_value, .read_data,
  .read_low_strobe, .read_high_strobe, .counter_overflow_flag, .clear_overflow_flag, .channel_event,
  .channel_event_flag, .clear_channel_flag, .irq_request, .global_irq_enable, .array_irq_enable, .cpu_idle,
  .idle_stop_control);
